// ---- include/sub_alu_if.sv ----
// Carrier between the core and its subtract unit
`timescale 1ns/1ps
interface sub_alu_if;
	logic [7:0] accum;
	logic [7:0] literal;
	logic [7:0] result;
	logic       carry;
	logic       nibble;
	logic       zero;
	modport alu  (input accum, input literal, output result, output carry, output nibble,
		output zero);
	modport core (output accum, output literal, input result, input carry, input nibble,
		input zero);
endinterface

// ---- include/sub_sleep_pkg.sv ----
// Constants for the power-down and literal-subtract execution block
// Contract
// - Power-down loads watchdog counter with zero and clears its prescaler.
// - Power-down clears power-down flag, sets expiry bit, touches no other status; the code also sets the halted status bit (bit 5).
// - Power-down opcode 00_0000_0110_0011, one word, one cycle, halts oscillator.
// - Opcode 11_110x_kkkk_kkkk computes literal minus accumulator, two's complement.
// - Literal is low eight bits; difference written into the accumulator.
// - Carry set when literal exceeds accumulator: no borrow.
// - Literal equal to accumulator gives zero result and carry set.
// - Accumulator above literal clears carry; result wraps to eight bits.
package sub_sleep_pkg;
	localparam int          INSTR_W          = 14;
	localparam int          DATA_W           = 8;
	localparam logic [13:0] OP_POWER_DOWN    = 14'h0063;
	localparam logic [4:0]  OP_SUB_LIT_HIGH  = 5'h1E;
	localparam int          SUB_LIT_POS      = 9;
	// Register byte offsets on the bus
	localparam logic [3:0]  OFF_ACCUM        = 4'h0;
	localparam logic [3:0]  OFF_STATUS       = 4'h4;
	localparam logic [3:0]  OFF_WATCHDOG     = 4'h8;
	localparam logic [3:0]  OFF_CONTROL      = 4'hC;
	// Status field positions
	localparam int          ST_CARRY         = 0;
	localparam int          ST_NIBBLE        = 1;
	localparam int          ST_ZERO          = 2;
	localparam int          ST_POWER_DOWN    = 3;
	localparam int          ST_EXPIRY        = 4;
	localparam int          ST_HALTED        = 5;
	// Watchdog register layout: counter low byte, prescaler next byte
	localparam int          WD_PRESCALE_POS  = 8;
	localparam int          CTRL_WAKE        = 0;
	// Values after reset
	localparam logic [7:0]  RST_ACCUM        = 8'h00;
	localparam logic [7:0]  RST_WATCHDOG     = 8'h00;
	localparam logic [7:0]  RST_PRESCALE     = 8'h00;
	localparam logic        RST_POWER_DOWN   = 1'b1;
	localparam logic        RST_EXPIRY       = 1'b1;
	localparam logic [1:0]  RESP_OKAY        = 2'b00;
	localparam logic [1:0]  RESP_SLVERR      = 2'b10;
	typedef enum logic [1:0] {
		CORE_RUN    = 2'b00,
		CORE_HALTED = 2'b01
	} core_state_t;
endpackage

// ---- logic/literal_minus_accumulator.sv ----
// Eight-bit literal minus accumulator with carry, nibble and zero flags
`timescale 1ns/1ps
module literal_minus_accumulator (
	sub_alu_if.alu port_alu
);
	wire [8:0] full_diff;
	wire [4:0] low_diff;

	// Extra top bit is the inverted borrow
	assign full_diff       = {1'b1, port_alu.literal} - {1'b0, port_alu.accum};
	assign low_diff        = {1'b1, port_alu.literal[3:0]} - {1'b0, port_alu.accum[3:0]};
	assign port_alu.result = full_diff[7:0];
	assign port_alu.carry  = full_diff[8];
	assign port_alu.nibble = low_diff[4];
	assign port_alu.zero   = (full_diff[7:0] == 8'h00);
endmodule

// ---- logic/sub_sleep_core.sv ----
// Execution of power-down and literal-subtract, with AXI4-Lite register access
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module sub_sleep_core (
	// Clock, reset, enable
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        ce,
	// Instruction from decode
	input  wire logic        instr_valid,
	input  wire logic [13:0] instr_word,
	// Core state
	output logic             oscillator_stop,
	output logic [7:0]       accumulator,
	output logic             carry_flag,
	output logic             nibble_borrow_flag,
	output logic             zero_flag,
	output logic             power_down_flag,
	output logic             expiry_status_bit,
	output logic [7:0]       watchdog_counter,
	output logic [7:0]       watchdog_prescaler,
	// AXI4-Lite write
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready
);
	sub_alu_if alu_link ();

	literal_minus_accumulator u_sub (
		.port_alu (alu_link.alu)
	);

	function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] val,
		input logic en);
		merge_byte = en ? val : old;
	endfunction

	function automatic logic mapped(input logic [3:0] addr);
		mapped = (addr == sub_sleep_pkg::OFF_ACCUM) || (addr == sub_sleep_pkg::OFF_STATUS) ||
			(addr == sub_sleep_pkg::OFF_WATCHDOG) || (addr == sub_sleep_pkg::OFF_CONTROL);
	endfunction

	sub_sleep_pkg::core_state_t state;
	sub_sleep_pkg::core_state_t next_state;

	logic       aw_got;
	logic       w_got;
	logic [3:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;

	// Instruction decode
	wire running   = (state == sub_sleep_pkg::CORE_RUN);
	wire exec      = instr_valid & running;
	wire do_sleep  = exec & (instr_word == sub_sleep_pkg::OP_POWER_DOWN);
	wire do_sub    = exec & (instr_word[13:sub_sleep_pkg::SUB_LIT_POS] ==
		sub_sleep_pkg::OP_SUB_LIT_HIGH);

	assign alu_link.accum   = accumulator;
	assign alu_link.literal = instr_word[7:0];

	// Write channel bookkeeping
	wire aw_fire    = awvalid & awready;
	wire w_fire     = wvalid & wready;
	wire wr_go      = aw_got & w_got & ~bvalid;
	wire b_fire     = bvalid & bready;
	wire next_aw_got = (aw_got | aw_fire) & ~wr_go;
	wire next_w_got  = (w_got | w_fire) & ~wr_go;
	wire next_bvalid = wr_go | (bvalid & ~b_fire);
	wire next_awready = ~next_aw_got & ~next_bvalid;
	wire next_wready  = ~next_w_got & ~next_bvalid;

	// Register write selects
	wire wr_ok      = wr_go & mapped(wr_addr);
	wire wr_accum   = wr_ok & (wr_addr == sub_sleep_pkg::OFF_ACCUM) & wr_strb[0];
	wire wr_status  = wr_ok & (wr_addr == sub_sleep_pkg::OFF_STATUS) & wr_strb[0];
	wire wr_wd      = wr_ok & (wr_addr == sub_sleep_pkg::OFF_WATCHDOG);
	wire wr_wake    = wr_ok & (wr_addr == sub_sleep_pkg::OFF_CONTROL) & wr_strb[0] &
		wr_data[sub_sleep_pkg::CTRL_WAKE];

	// Read channel
	wire ar_fire     = arvalid & arready;
	wire r_fire      = rvalid & rready;
	wire next_rvalid = ar_fire | (rvalid & ~r_fire);
	wire next_arready = ~next_rvalid;

	wire [7:0] status_view = {2'b00, oscillator_stop, expiry_status_bit, power_down_flag,
		zero_flag, nibble_borrow_flag, carry_flag};
	wire [31:0] read_word =
		(araddr == sub_sleep_pkg::OFF_ACCUM)    ? {24'h00_0000, accumulator} :
		(araddr == sub_sleep_pkg::OFF_STATUS)   ? {24'h00_0000, status_view} :
		(araddr == sub_sleep_pkg::OFF_WATCHDOG) ? {16'h0000, watchdog_prescaler,
			watchdog_counter} :
		32'h0000_0000;

	// Next values of the core state; instruction wins over a bus write in the same cycle
	wire [7:0] next_accum = do_sub ? alu_link.result :
		wr_accum ? wr_data[7:0] : accumulator;
	wire next_carry  = do_sub ? alu_link.carry :
		wr_status ? wr_data[sub_sleep_pkg::ST_CARRY] : carry_flag;
	wire next_nibble = do_sub ? alu_link.nibble :
		wr_status ? wr_data[sub_sleep_pkg::ST_NIBBLE] : nibble_borrow_flag;
	wire next_zero   = do_sub ? alu_link.zero :
		wr_status ? wr_data[sub_sleep_pkg::ST_ZERO] : zero_flag;
	wire [7:0] next_wd = do_sleep ? sub_sleep_pkg::RST_WATCHDOG :
		merge_byte(watchdog_counter, wr_data[7:0], wr_wd & wr_strb[0]);
	wire [7:0] next_pre = do_sleep ? sub_sleep_pkg::RST_PRESCALE :
		merge_byte(watchdog_prescaler, wr_data[15:8], wr_wd & wr_strb[1]);

	always_comb begin
		next_state = state;
		case (state)
			sub_sleep_pkg::CORE_RUN: begin
				if (do_sleep) begin
					next_state = sub_sleep_pkg::CORE_HALTED;
				end
			end
			sub_sleep_pkg::CORE_HALTED: begin
				if (wr_wake) begin
					next_state = sub_sleep_pkg::CORE_RUN;
				end
			end
			default: begin
				next_state = sub_sleep_pkg::CORE_RUN;
			end
		endcase
	end

	// Bus slave state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_got  <= 1'b0;
			w_got   <= 1'b0;
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			arready <= 1'b0;
			rvalid  <= 1'b0;
		end else if (ce) begin
			aw_got  <= next_aw_got;
			w_got   <= next_w_got;
			awready <= next_awready;
			wready  <= next_wready;
			bvalid  <= next_bvalid;
			arready <= next_arready;
			rvalid  <= next_rvalid;
		end
	end

	// Bus payload capture
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_addr <= 4'h0;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
			bresp   <= sub_sleep_pkg::RESP_OKAY;
			rdata   <= 32'h0000_0000;
			rresp   <= sub_sleep_pkg::RESP_OKAY;
		end else if (ce) begin
			if (aw_fire) begin
				wr_addr <= awaddr;
			end
			if (w_fire) begin
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			if (wr_go) begin
				bresp <= mapped(wr_addr) ? sub_sleep_pkg::RESP_OKAY : sub_sleep_pkg::RESP_SLVERR;
			end
			if (ar_fire) begin
				rdata <= read_word;
				rresp <= mapped(araddr) ? sub_sleep_pkg::RESP_OKAY : sub_sleep_pkg::RESP_SLVERR;
			end
		end
	end

	// Arithmetic state; untouched by power-down
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			accumulator        <= sub_sleep_pkg::RST_ACCUM;
			carry_flag         <= 1'b0;
			nibble_borrow_flag <= 1'b0;
			zero_flag          <= 1'b0;
		end else if (ce) begin
			accumulator        <= next_accum;
			carry_flag         <= next_carry;
			nibble_borrow_flag <= next_nibble;
			zero_flag          <= next_zero;
		end
	end

	// Power-down state; subtract never reaches these
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state              <= sub_sleep_pkg::CORE_RUN;
			oscillator_stop    <= 1'b0;
			power_down_flag    <= sub_sleep_pkg::RST_POWER_DOWN;
			expiry_status_bit  <= sub_sleep_pkg::RST_EXPIRY;
			watchdog_counter   <= sub_sleep_pkg::RST_WATCHDOG;
			watchdog_prescaler <= sub_sleep_pkg::RST_PRESCALE;
		end else if (ce) begin
			state              <= next_state;
			oscillator_stop    <= (next_state == sub_sleep_pkg::CORE_HALTED);
			watchdog_counter   <= next_wd;
			watchdog_prescaler <= next_pre;
			if (do_sleep) begin
				power_down_flag   <= 1'b0;
				expiry_status_bit <= 1'b1;
			end
		end
	end
endmodule

// ---- tb/sub_sleep_props.sv ----
// Concurrent checks on the execution block ports
`timescale 1ns/1ps
module sub_sleep_props (
	// Clock, reset, control
	input wire logic        clk, reset_n, ce, instr_valid, awready,
	input wire logic [13:0] instr_word,
	// Core state
	input wire logic        oscillator_stop, carry_flag, nibble_borrow_flag, zero_flag,
	input wire logic        power_down_flag, expiry_status_bit,
	input wire logic [7:0]  accumulator, watchdog_counter, watchdog_prescaler
);
	wire logic take     = ce && instr_valid && !oscillator_stop;
	wire logic is_sleep = take && instr_word == sub_sleep_pkg::OP_POWER_DOWN;
	wire logic is_sub   = take && instr_word[13:9] == sub_sleep_pkg::OP_SUB_LIT_HIGH;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_wd_cleared: assert property (is_sleep |=> watchdog_counter == 8'h00 &&
		watchdog_prescaler == 8'h00) else $error("watchdog not cleared");
	a_status_update: assert property (is_sleep |=> !power_down_flag && expiry_status_bit)
		else $error("status bits wrong after power-down");
	a_sleep_halts: assert property (is_sleep |=> oscillator_stop)
		else $error("core did not halt");
	a_sleep_keeps: assert property (is_sleep && awready |=> $stable(accumulator) &&
		$stable({carry_flag, nibble_borrow_flag, zero_flag})) else $error("power-down changed data");
	a_sub_result: assert property (is_sub |=>
		accumulator == $past(instr_word[7:0]) - $past(accumulator)) else $error("difference wrong");
	a_carry_borrow: assert property (is_sub |=>
		carry_flag == ($past(instr_word[7:0]) >= $past(accumulator))) else $error("carry wrong");
	a_nibble_zero: assert property (is_sub |=> zero_flag == (accumulator == 8'h00) &&
		nibble_borrow_flag == ($past(instr_word[3:0]) >= $past(accumulator[3:0])))
		else $error("nibble or zero flag wrong");
	a_halt_refuses: assert property (oscillator_stop && ce && instr_valid && awready
		|=> $stable(accumulator) && $stable(carry_flag)) else $error("halted core executed");
	c_sub: cover property (is_sub && instr_word[8]);
	c_sleep: cover property (is_sleep);
	c_halted_instr: cover property (oscillator_stop && instr_valid);
endmodule
bind sub_sleep_core sub_sleep_props u_props (.clk(clk), .reset_n(reset_n), .ce(ce),
	.instr_valid(instr_valid), .awready(awready), .instr_word(instr_word),
	.oscillator_stop(oscillator_stop), .carry_flag(carry_flag),
	.nibble_borrow_flag(nibble_borrow_flag), .zero_flag(zero_flag),
	.power_down_flag(power_down_flag), .expiry_status_bit(expiry_status_bit),
	.accumulator(accumulator), .watchdog_counter(watchdog_counter),
	.watchdog_prescaler(watchdog_prescaler));

// ---- tb/tb.sv ----
// Self-checking bench for power-down and literal subtract
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
	$display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module tb;
	logic        clk = 0, reset_n = 0, ce = 1, instr_valid = 0;
	logic [13:0] instr_word = 14'h0000;
	logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
	logic [31:0] wdata = 32'h0000_0000, rdata, rd;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, osc, cf, nf, zf, pdf, exf;
	logic [1:0]  bresp, rresp, rsp;
	logic [7:0]  acc, wdc, wdp, a, k, res;
	int          err_total = 0, num_checks = 0, cycles = 0;
	sub_sleep_core dut (.clk(clk), .reset_n(reset_n), .ce(ce), .instr_valid(instr_valid),
		.instr_word(instr_word), .oscillator_stop(osc), .accumulator(acc), .carry_flag(cf),
		.nibble_borrow_flag(nf), .zero_flag(zf), .power_down_flag(pdf),
		.expiry_status_bit(exf), .watchdog_counter(wdc), .watchdog_prescaler(wdp),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Hang guard: whole sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			summarize();
		end
	end
	task automatic wr(input logic [3:0] ad, input logic [31:0] d);
		@(posedge clk);
		awaddr <= ad; wdata <= d; wstrb <= 4'hF; awvalid <= 1; wvalid <= 1; bready <= 1;
		while (awvalid || wvalid || !bvalid) begin
			@(posedge clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end
		bready <= 0;
		`CHK(bresp, sub_sleep_pkg::RESP_OKAY)
	endtask
	task automatic rdx(input logic [3:0] ad, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= ad; arvalid <= 1; rready <= 1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 0;
		end while (!rvalid);
		d = rdata; r = rresp;
		rready <= 0;
	endtask
	task automatic exec(input logic [13:0] w);
		@(posedge clk);
		instr_valid <= 1; instr_word <= w;
		@(posedge clk);
		instr_valid <= 0;
		#1;
	endtask
	logic [7:0] ta [6] = '{8'h01, 8'h02, 8'h03, 8'h0F, 8'h00, 8'hFF};
	logic [7:0] tk [6] = '{8'h02, 8'h02, 8'h02, 8'h10, 8'hFF, 8'h00};
	initial begin
		repeat (12) @(posedge clk);
		reset_n <= 1;
		repeat (2) @(posedge clk);
		`CHK({pdf, exf, osc, acc}, {1'b1, 1'b1, 1'b0, 8'h00})
		for (int i = 0; i < 6; i++) begin
			a = ta[i]; k = tk[i]; res = k - a;
			wr(4'h0, {24'h00_0000, a});
			exec({5'h1E, i[0], k});
			`CHK(acc, res)
			`CHK(cf, k >= a)
			`CHK({nf, zf}, {k[3:0] >= a[3:0], res == 8'h00})
		end
		wr(4'h8, 32'h0000_1234);
		wr(4'h4, 32'h0000_0007);
		// Counter must hold a nonzero value, or the clear below proves nothing
		rdx(4'h8, rd, rsp);
		`CHK(rd, 32'h0000_1234)
		exec(sub_sleep_pkg::OP_POWER_DOWN);
		`CHK({wdc, wdp}, 16'h0000)
		`CHK({pdf, exf, cf, nf, zf, acc}, {5'b01111, 8'h01})
		`CHK(osc, 1'b1)
		rdx(4'h4, rd, rsp);
		`CHK(rd, 32'h0000_0037)
		exec(14'h3C50);
		`CHK(acc, 8'h01)
		wr(4'hC, 32'h0000_0001);
		`CHK(osc, 1'b0)
		exec(14'h3C50);
		`CHK({acc, cf}, {8'h4F, 1'b1})
		`CHK({nf, zf, pdf, exf, wdc, wdp}, {4'b0001, 16'h0000})
		// Enable low must freeze the core, so the instruction is lost
		@(posedge clk);
		ce <= 1'b0;
		exec(14'h3C50);
		`CHK({acc, cf}, {8'h4F, 1'b1})
		@(posedge clk);
		ce <= 1'b1;
		rdx(4'h2, rd, rsp);
		`CHK(rsp, sub_sleep_pkg::RESP_SLVERR)
		`CHK(rd, 32'h0000_0000)
		summarize();
	end
endmodule
